// ---- core/iedc_consts.svh ----
`ifndef IEDC_CONSTS_SVH
`define IEDC_CONSTS_SVH

// Register byte offsets
`define IEDC_OFF_ENABLE      12'h038
`define IEDC_OFF_DROPS       12'h040
`define IEDC_ADDR_W          12

// Enable register fields
`define IEDC_BIT_TX_DONE     0
`define IEDC_BIT_TX_STOP     1
`define IEDC_BIT_TX_NOBUF    2
`define IEDC_BIT_TX_JABBER   3
`define IEDC_BIT_TX_UNDER    5
`define IEDC_BIT_RX_DONE     6
`define IEDC_BIT_RX_NOBUF    7
`define IEDC_BIT_RX_STOP     8
`define IEDC_BIT_ABNORMAL    15
`define IEDC_BIT_NORMAL      16
`define IEDC_ENABLE_RESET    32'hfffe_0000
`define IEDC_ENABLE_WMASK    32'h0001_81ef

// Drop counter fields
`define IEDC_BIT_OVF_WRAP    31
`define IEDC_OVF_HI          30
`define IEDC_OVF_LO          17
`define IEDC_BIT_MISS_WRAP   16
`define IEDC_MISS_HI         15
`define IEDC_MISS_LO         0
`define IEDC_DROPS_RESET     32'h0000_0000

`endif

// ---- core/iedc_pkg.sv ----
package iedc_pkg;
   typedef enum logic [1:0] {
      IEDC_SEL_NONE,
      IEDC_SEL_ENABLE,
      IEDC_SEL_DROPS
   } iedc_sel_t;
endpackage : iedc_pkg

// ---- core/iedc_irq_enable.sv ----
`timescale 1ns/1ps
`include "iedc_consts.svh"

// Behaviour
// RL1 - Receive-stopped interrupt needs enable bit 8, abnormal summary, flag.
// RL2 - Receive-buffer-unavailable interrupt needs bit 7, abnormal summary, flag.
// RL3 - Receive-complete interrupt needs bit 6, normal summary, flag.
// RL4 - Transmit-underflow interrupt needs bit 5, abnormal summary, flag.
// RL5 - Jabber-timeout interrupt needs bit 3, abnormal summary, flag.
// RL6 - Transmit-buffer-unavailable interrupt needs bit 2, normal summary, flag.
// RL7 - Transmit-stopped interrupt needs bit 1, abnormal summary, flag.
// RL8 - Transmit-complete interrupt needs bit 0, normal summary, flag.
// RL9 - Clear individual enable blocks its source even with flag set.
// RL10 - Enable register resets to FFFE0000, upper unused bits read one.
// RL11 - Bit 31 sets on overflow-counter wrap, clears on read.
// RL12 - Bits 30:17 count FIFO-overflow drops, cleared by read.
// RL13 - Bit 16 sets on missed-frame counter wrap, clears on read.
// RL14 - Bits 15:0 count no-descriptor drops, cleared by read.
// RL15 - Drop register resets to zero, is read-only, writes ignored.
// RL16 - Normal summary bit 16 gates transmit/receive complete and tx nobuf.
// RL17 - Abnormal summary bit 15 gates all error and stop sources.
// RL18 - Hardware or software reset disables every source.
// RL19 - Interrupt output high while any source fully enabled.
module iedc_irq_enable #(
   parameter int OVF_W  = 14,
   parameter int MISS_W = 16
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        soft_reset,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic [8:0]  interrupt_status_flags,
   input  wire logic        ovf_drop,
   input  wire logic        miss_drop,
   output logic             irq
);

   // ****************************************************************
   // Bus address phase
   // ****************************************************************
   logic                  ph_valid;
   logic                  ph_write;
   logic [`IEDC_ADDR_W-1:0] ph_addr;
   logic [31:0]           interrupt_enable_mask;
   logic                  ovf_wrap;
   logic [OVF_W-1:0]      ovf_count;
   logic                  miss_wrap;
   logic [MISS_W-1:0]     miss_count;

   wire addr_take = hsel & hready & htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_valid <= 1'b0;
         ph_write <= 1'b0;
         ph_addr  <= '0;
      end else begin
         ph_valid <= addr_take;
         ph_write <= hwrite;
         ph_addr  <= haddr[`IEDC_ADDR_W-1:0];
      end
   end

   wire iedc_pkg::iedc_sel_t sel =
      !ph_valid ? iedc_pkg::IEDC_SEL_NONE :
      (ph_addr == `IEDC_OFF_ENABLE) ? iedc_pkg::IEDC_SEL_ENABLE :
      (ph_addr == `IEDC_OFF_DROPS) ? iedc_pkg::IEDC_SEL_DROPS :
      iedc_pkg::IEDC_SEL_NONE;

   wire en_write   = (sel == iedc_pkg::IEDC_SEL_ENABLE) & ph_write;
   wire drops_read = (sel == iedc_pkg::IEDC_SEL_DROPS) & !ph_write;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // ****************************************************************
   // Enable register
   // ****************************************************************
   // Soft reset clears like hardware reset so no source survives it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         interrupt_enable_mask <= `IEDC_ENABLE_RESET; // see RL10
      end else if (soft_reset) begin
         interrupt_enable_mask <= `IEDC_ENABLE_RESET; // see RL18
      end else if (en_write) begin
         interrupt_enable_mask <= (hwdata & `IEDC_ENABLE_WMASK)
                                | `IEDC_ENABLE_RESET;
      end
   end

   wire normal_summary_enable   = interrupt_enable_mask[`IEDC_BIT_NORMAL];
   wire abnormal_summary_enable = interrupt_enable_mask[`IEDC_BIT_ABNORMAL];
   wire rx_stopped_enable = interrupt_enable_mask[`IEDC_BIT_RX_STOP];
   wire rx_buffer_unavailable_enable =
      interrupt_enable_mask[`IEDC_BIT_RX_NOBUF];
   wire rx_complete_enable  = interrupt_enable_mask[`IEDC_BIT_RX_DONE];
   wire tx_underflow_enable = interrupt_enable_mask[`IEDC_BIT_TX_UNDER];
   wire tx_jabber_timeout_enable =
      interrupt_enable_mask[`IEDC_BIT_TX_JABBER];
   wire tx_buffer_unavailable_enable =
      interrupt_enable_mask[`IEDC_BIT_TX_NOBUF];
   wire tx_stopped_enable  = interrupt_enable_mask[`IEDC_BIT_TX_STOP];
   wire tx_complete_enable = interrupt_enable_mask[`IEDC_BIT_TX_DONE];

   // ****************************************************************
   // Interrupt gating
   // ****************************************************************
   wire [8:0] f = interrupt_status_flags;
   wire src_rx_stop = rx_stopped_enable & abnormal_summary_enable
                    & f[`IEDC_BIT_RX_STOP]; // see RL1
   wire src_rx_nobuf = rx_buffer_unavailable_enable
                     & abnormal_summary_enable
                     & f[`IEDC_BIT_RX_NOBUF]; // see RL2
   wire src_rx_done = rx_complete_enable & normal_summary_enable
                    & f[`IEDC_BIT_RX_DONE]; // see RL3
   wire src_tx_under = tx_underflow_enable & abnormal_summary_enable
                     & f[`IEDC_BIT_TX_UNDER]; // see RL4
   wire src_tx_jab = tx_jabber_timeout_enable & abnormal_summary_enable
                   & f[`IEDC_BIT_TX_JABBER]; // see RL5
   wire src_tx_nobuf = tx_buffer_unavailable_enable
                     & normal_summary_enable
                     & f[`IEDC_BIT_TX_NOBUF]; // see RL6
   wire src_tx_stop = tx_stopped_enable & abnormal_summary_enable
                    & f[`IEDC_BIT_TX_STOP]; // see RL7
   wire src_tx_done = tx_complete_enable & normal_summary_enable
                    & f[`IEDC_BIT_TX_DONE]; // see RL8

   // Summary gates feed every term: see RL9 see RL16 see RL17
   wire next_irq = src_rx_stop | src_rx_nobuf | src_rx_done
                 | src_tx_under | src_tx_jab | src_tx_nobuf
                 | src_tx_stop | src_tx_done;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= next_irq; // see RL19
      end
   end

   // ****************************************************************
   // Drop counters
   // ****************************************************************
   // A drop that lands in the read cycle counts as one in the fresh
   // count so no event is lost across the clear
   wire [OVF_W:0]  ovf_sum  = {1'b0, ovf_count} + (OVF_W+1)'(1);
   wire [MISS_W:0] miss_sum = {1'b0, miss_count} + (MISS_W+1)'(1);
   wire [OVF_W-1:0] ovf_base =
      drops_read ? '0 : ovf_count;
   wire [MISS_W-1:0] miss_base =
      drops_read ? '0 : miss_count;
   wire ovf_rolls  = ovf_drop & ovf_sum[OVF_W] & !drops_read;
   wire miss_rolls = miss_drop & miss_sum[MISS_W] & !drops_read;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ovf_count  <= '0; // see RL15
         miss_count <= '0;
         ovf_wrap   <= 1'b0;
         miss_wrap  <= 1'b0;
      end else begin
         ovf_count  <= ovf_drop ? (drops_read ? OVF_W'(1) :
                       ovf_sum[OVF_W-1:0]) : ovf_base; // see RL12
         miss_count <= miss_drop ? (drops_read ? MISS_W'(1) :
                       miss_sum[MISS_W-1:0]) : miss_base; // see RL14
         ovf_wrap   <= ovf_rolls | (ovf_wrap & !drops_read); // see RL11
         miss_wrap  <= miss_rolls | (miss_wrap & !drops_read); // see RL13
      end
   end

   // ****************************************************************
   // Read data
   // ****************************************************************
   wire [31:0] drops_word = {ovf_wrap, ovf_count, miss_wrap, miss_count};
   // Writes to the drop register fall through: see RL15
   wire [31:0] next_rdata =
      (sel == iedc_pkg::IEDC_SEL_ENABLE) ? interrupt_enable_mask :
      (sel == iedc_pkg::IEDC_SEL_DROPS) ? drops_word : 32'h0000_0000;

   assign hrdata = ph_write ? 32'h0000_0000 : next_rdata;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   sequence s_drop_read;
      drops_read;
   endsequence

   // A software reset in the same cycle wins over the bus write
   sequence s_enable_write;
      en_write & !soft_reset;
   endsequence

   AST_RX_STOP: assert property (@(posedge hclk) disable iff (!hresetn)
      src_rx_stop |=> irq) // see RL1
      else $error("rx stop source did not raise irq");
   AST_NORMAL_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
      !normal_summary_enable & !abnormal_summary_enable |=> !irq) // see RL16
      else $error("irq with both summaries clear");
   AST_ABN_GATE: assert property (@(posedge hclk) disable iff (!hresetn)
      !abnormal_summary_enable & !(f[0] | f[2] | f[6]) |=> !irq) // see RL17
      else $error("abnormal source passed closed gate");
   AST_ENABLE_UPPER: assert property (@(posedge hclk) disable iff (!hresetn)
      interrupt_enable_mask[31:17] == 15'h7fff) // see RL10
      else $error("enable upper bits not ones");
   AST_SOFT_RESET: assert property (@(posedge hclk) disable iff (!hresetn)
      soft_reset |=> interrupt_enable_mask == `IEDC_ENABLE_RESET) // see RL18
      else $error("soft reset left a source enabled");
   AST_READ_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
      s_drop_read ##0 !ovf_drop & !miss_drop |=> drops_word == '0) // see RL12
      else $error("drop register not cleared by read");
   AST_MISS_COUNT: assert property (@(posedge hclk) disable iff (!hresetn)
      miss_drop & !drops_read & !miss_count[0]
      |=> miss_count == $past(miss_count) + MISS_W'(1)) // see RL14
      else $error("missed frame count not advanced");
   AST_MISS_WRAP: assert property (@(posedge hclk) disable iff (!hresetn)
      miss_rolls |=> miss_wrap && miss_count == '0) // see RL13
      else $error("missed frame wrap not flagged");
   AST_OVF_WRAP: assert property (@(posedge hclk) disable iff (!hresetn)
      ovf_rolls |=> ovf_wrap ##1 (ovf_wrap || $past(drops_read))) // see RL11
      else $error("overflow wrap not held");
   AST_NO_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
      (sel == iedc_pkg::IEDC_SEL_DROPS) & ph_write & !ovf_drop & !miss_drop
      |=> drops_word == $past(drops_word)) // see RL15
      else $error("write changed drop register");
   AST_IRQ_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
      !next_irq |=> !irq) // see RL19
      else $error("irq without enabled source");

   // Gating of every source but rx stop is checked on the raw enable bits, not on the
   // source terms, so a miswired term cannot hide behind itself
   AST_RX_NOBUF: assert property (@(posedge hclk) disable iff (!hresetn)
      interrupt_enable_mask[7] & interrupt_enable_mask[15] & f[7] |=> irq) // see RL2
      else $error("rx buffer source did not raise irq");
   AST_RX_DONE: assert property (@(posedge hclk) disable iff (!hresetn)
      interrupt_enable_mask[6] & interrupt_enable_mask[16] & f[6] |=> irq) // see RL3
      else $error("rx complete source did not raise irq");
   AST_TX_UNDER: assert property (@(posedge hclk) disable iff (!hresetn)
      interrupt_enable_mask[5] & interrupt_enable_mask[15] & f[5] |=> irq) // see RL4
      else $error("tx underflow source did not raise irq");
   AST_TX_JAB: assert property (@(posedge hclk) disable iff (!hresetn)
      interrupt_enable_mask[3] & interrupt_enable_mask[15] & f[3] |=> irq) // see RL5
      else $error("jabber source did not raise irq");
   AST_TX_NOBUF: assert property (@(posedge hclk) disable iff (!hresetn)
      interrupt_enable_mask[2] & interrupt_enable_mask[16] & f[2] |=> irq) // see RL6
      else $error("tx buffer source did not raise irq");
   AST_TX_STOP: assert property (@(posedge hclk) disable iff (!hresetn)
      interrupt_enable_mask[1] & interrupt_enable_mask[15] & f[1] |=> irq) // see RL7
      else $error("tx stop source did not raise irq");
   AST_TX_DONE: assert property (@(posedge hclk) disable iff (!hresetn)
      interrupt_enable_mask[0] & interrupt_enable_mask[16] & f[0] |=> irq) // see RL8
      else $error("tx complete source did not raise irq");

   // Masking every source must silence the line whatever the flags say
   AST_ALL_MASKED: assert property (@(posedge hclk) disable iff (!hresetn)
      interrupt_enable_mask[8:0] == 9'h000 |=> !irq) // see RL9
      else $error("irq with every source masked");
   AST_NORMAL_ONLY: assert property (@(posedge hclk) disable iff (!hresetn)
      !normal_summary_enable & !(f[1] | f[3] | f[5] | f[7] | f[8])
      |=> !irq) // see RL16
      else $error("normal source passed closed gate");

   // Written value lands masked, upper bits forced to ones
   AST_ENABLE_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
      s_enable_write |=> interrupt_enable_mask ==
      (($past(hwdata) & `IEDC_ENABLE_WMASK) | `IEDC_ENABLE_RESET)) // see RL10
      else $error("enable write did not land");
   AST_SOFT_IRQ: assert property (@(posedge hclk) disable iff (!hresetn)
      soft_reset |-> ##2 !irq) // see RL18
      else $error("irq survived soft reset");

   // Outside a data phase the read bus stays quiet
   AST_HRDATA_IDLE: assert property (@(posedge hclk) disable iff (!hresetn)
      !ph_valid |-> hrdata == 32'h0000_0000) // see RL15
      else $error("read data outside data phase");

   // Even counts never roll, so the step is a plain increment
   AST_OVF_COUNT: assert property (@(posedge hclk) disable iff (!hresetn)
      ovf_drop & !drops_read & !ovf_count[0]
      |=> ovf_count == $past(ovf_count) + OVF_W'(1)) // see RL12
      else $error("overflow count not advanced");
   AST_DROP_IN_READ: assert property (@(posedge hclk) disable iff (!hresetn)
      s_drop_read ##0 miss_drop |=> miss_count == MISS_W'(1)) // see RL14
      else $error("drop in read cycle lost");

endmodule : iedc_irq_enable

// ---- sim/irq_enable_and_drop_counters_tb_top.sv ----
`timescale 1ns/1ps
`include "iedc_consts.svh"

// ********************************
// Bench top
// ********************************
module irq_enable_and_drop_counters_tb_top;
   localparam int LIMIT = 90000;
   logic        hclk            = 1'b0;
   logic        hresetn         = 1'b0;
   logic        soft_reset      = 1'b0;
   logic        hsel            = 1'b0;
   logic [31:0] haddr           = 32'h0000_0000;
   logic [1:0]  htrans          = 2'b00;
   logic        hwrite          = 1'b0;
   logic [2:0]  hsize           = 3'h2;
   logic [31:0] hwdata          = 32'h0000_0000;
   logic [8:0]  flags           = 9'h000;
   logic        ovf_drop        = 1'b0;
   logic        miss_drop       = 1'b0;
   logic [31:0] seed            = 32'h0000_f67c;
   logic [31:0] rd;
   logic [31:0] en;
   logic [4:0]  n_ovf;
   logic [4:0]  n_miss;
   int          n_mismatch      = 0;
   int          samples_checked = 0;
   int          cyc             = 0;
   wire  [31:0] hrdata;
   wire         hreadyout;
   wire         hresp;
   wire         hready;
   wire         irq;

   // Single slave, so its own ready closes the loop
   assign hready = hreadyout;

   iedc_irq_enable dut (
      .hclk(hclk), .hresetn(hresetn), .soft_reset(soft_reset),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp),
      .interrupt_status_flags(flags), .ovf_drop(ovf_drop),
      .miss_drop(miss_drop), .irq(irq)
   );

   always #20 hclk = ~hclk;

   // ********************************
   // Helpers
   // ********************************
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // Normal group is bits 0,2,6; abnormal group is bits 1,3,5,7,8
   function automatic logic exp_irq(logic [31:0] e, logic [8:0] f);
      logic [8:0] hit;
      hit = f & e[8:0] & 9'h1ef;
      return (e[16] & |(hit & 9'h045)) | (e[15] & |(hit & 9'h1aa));
   endfunction : exp_irq

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic final_report();
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : final_report

   // Entered just after a rising edge; data taken at the closing edge
   task automatic xfer(logic wr, logic [31:0] a, logic [31:0] wd,
                       output logic [31:0] rdat);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'b1);
      rdat = hrdata;
   endtask : xfer

   task automatic apply(logic [31:0] e, logic [8:0] f);
      xfer(1'b1, `IEDC_OFF_ENABLE, e, rd);
      flags <= f;
      xfer(1'b0, `IEDC_OFF_ENABLE, 32'h0000_0000, rd);
      check("enable", rd, (e & 32'h0001_81ef) | 32'hfffe_0000);
      repeat (2) @(posedge hclk);
      check("irq", irq, exp_irq(e, f));
   endtask : apply

   always @(posedge hclk) begin
      cyc++;
      if (cyc == LIMIT) begin
         n_mismatch++;
         final_report();
      end
   end

   // ********************************
   // Scenarios
   // ********************************
   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      flags   <= 9'h1ff;
      @(posedge hclk);
      xfer(1'b0, `IEDC_OFF_ENABLE, 32'h0000_0000, rd);
      check("enable reset", rd, 32'hfffe_0000);
      xfer(1'b0, `IEDC_OFF_DROPS, 32'h0000_0000, rd);
      check("drops reset", rd, 32'h0000_0000);
      check("irq reset", irq, 1'b0);
      check("hresp", hresp, 1'b0);
      check("hreadyout", hreadyout, 1'b1);
      xfer(1'b0, 32'h0000_0100, 32'h0000_0000, rd);
      check("unmapped", rd, 32'h0000_0000);
      // Each source with its own summary, the other one, and masked alone
      for (int i = 0; i <= 8; i++) begin
         for (int k = 0; k < 3; k++) begin
            en = (k == 2) ? (32'h0001_81ef & ~(32'h1 << i)) :
                 ((32'h1 << i) | ((k == 0) ? 32'h0001_0000 : 32'h0000_8000));
            apply(en, 9'h001 << i);
         end
      end
      for (int r = 0; r < 40; r++) begin
         en = rnd();
         apply(en, 9'(rnd()));
      end
      apply(32'h0001_81ef, 9'h1ff);
      soft_reset <= 1'b1;
      @(posedge hclk);
      soft_reset <= 1'b0;
      xfer(1'b0, `IEDC_OFF_ENABLE, 32'h0000_0000, rd);
      check("enable soft", rd, 32'hfffe_0000);
      check("irq soft", irq, 1'b0);
      // Hardware reset in mid-run must close every source again
      apply(32'h0001_81ef, 9'h1ff);
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check("irq hard", irq, 1'b0);
      xfer(1'b0, `IEDC_OFF_ENABLE, 32'h0000_0000, rd);
      check("enable hard", rd, 32'hfffe_0000);
      for (int r = 0; r < 4; r++) begin
         n_ovf  = 5'(rnd());
         n_miss = 5'(rnd());
         for (int c = 0; c < 32; c++) begin
            ovf_drop  <= (c < n_ovf);
            miss_drop <= (c < n_miss);
            @(posedge hclk);
         end
         xfer(1'b1, `IEDC_OFF_DROPS, rnd(), rd);
         xfer(1'b0, `IEDC_OFF_DROPS, 32'h0000_0000, rd);
         check("drops", rd, {1'b0, 14'(n_ovf), 1'b0, 16'(n_miss)});
         xfer(1'b0, `IEDC_OFF_DROPS, 32'h0000_0000, rd);
         check("drops clear", rd, 32'h0000_0000);
      end
      // A drop every cycle rolls both counters over to zero
      ovf_drop  <= 1'b1;
      miss_drop <= 1'b1;
      repeat (65536) @(posedge hclk);
      ovf_drop  <= 1'b0;
      miss_drop <= 1'b0;
      xfer(1'b0, `IEDC_OFF_DROPS, 32'h0000_0000, rd);
      check("drops wrap", rd, 32'h8001_0000);
      xfer(1'b0, `IEDC_OFF_DROPS, 32'h0000_0000, rd);
      check("wrap clear", rd, 32'h0000_0000);
      final_report();
   end
endmodule : irq_enable_and_drop_counters_tb_top
